// File: tdtc_pkg.sv
// constants and types for the text display timing and cursor block
// Operation
// RQ1 - All timing derives from one 10.8864 MHz oscillator clocking the dot counter.
// RQ2 - Dot counter loads 10, counts to 15, wraps to zero, reloads 10.
// RQ3 - Dot counter top bit advances the character position counter once per cell.
// RQ4 - Character position counter gives 96 character times per scan.
// RQ5 - Position wrap advances scan counter; scan wrap advances line counter.
// RQ6 - Ten scans per character row, each a full 96 character times.
// RQ7 - Line counter runs zero to 26; its top output toggles per frame.
// RQ8 - Lines 0 to 23 displayed, lines 24 to 26 are vertical retrace.
// RQ9 - Cell is 7 dots by 10 scans; glyph is 5 by 7 inside.
// RQ10 - Horizontal drive high for 40 character times after visible region.
// RQ11 - Vertical drive high while line counter holds 24.
// RQ12 - Cursor match asserts when cursor row and column equal beam counters.
// RQ13 - Cursor row, column and scroll offset form the write address.
// RQ14 - Cursor moves up, down, right, left and home.
// RQ15 - Line feed increments the cursor row by one.
// RQ16 - Carriage return clears the cursor column.
// RQ17 - Protected layout mode wraps cursor from bottom line to top.
// RQ18 - Otherwise advancing beyond row 23 scrolls instead of wrapping.
// RQ19 - Scroll on line feed, cursor down, or advancing past last position.
// RQ20 - Video shift register loads on low dot msb strobe, shifts per clock.
// RQ21 - Reset presets dot counter and clears all other counters.
package tdtc_pkg;
    localparam logic [3:0] DOT_PRESET    = 4'hA;
    localparam logic [3:0] DOT_TOP       = 4'hF;
    localparam logic [6:0] COL_LAST      = 7'h5F;
    localparam logic [6:0] COL_VISIBLE   = 7'h50;
    localparam logic [6:0] HDRIVE_LEN    = 7'h28;
    localparam logic [3:0] SCAN_LAST     = 4'h9;
    localparam logic [4:0] LINE_LAST     = 5'h1A;
    localparam logic [4:0] LINE_VDRIVE   = 5'h18;
    localparam logic [4:0] ROW_LAST      = 5'h17;
    localparam logic [6:0] CUR_COL_LAST  = 7'h4F;
    localparam int         SHIFT_W       = 7;

    typedef enum logic [2:0] {
        TDTC_CMD_NONE,
        TDTC_CMD_UP,
        TDTC_CMD_DOWN,
        TDTC_CMD_RIGHT,
        TDTC_CMD_LEFT,
        TDTC_CMD_HOME,
        TDTC_CMD_LF,
        TDTC_CMD_CR
    } tdtc_cmd_t;

    typedef struct packed {
        logic [4:0] line;
        logic [3:0] scan;
        logic [6:0] col;
        logic [3:0] dot;
    } tdtc_beam_t;

    typedef struct packed {
        logic [4:0] row;
        logic [6:0] col;
        logic [4:0] roll;
    } tdtc_cursor_t;
endpackage

// File: tdtc_shift.sv
// video shift register, parallel load and serial dot output
`timescale 1ns/100ps
`default_nettype none
module tdtc_shift (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_ce,
    input  wire logic                       i_load_n,
    input  wire logic [tdtc_pkg::SHIFT_W-1:0] i_pattern,
    output logic                            o_dot
);
    logic [tdtc_pkg::SHIFT_W-1:0] sr;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sr <= '0;
        end else if (i_ce) begin
            if (!i_load_n) begin
                sr <= i_pattern; // [RQ20]
            end else begin
                sr <= {sr[tdtc_pkg::SHIFT_W-2:0], 1'b0}; // [RQ20]
            end
        end
    end
    assign o_dot = sr[tdtc_pkg::SHIFT_W-1];
endmodule // tdtc_shift
`default_nettype wire

// File: tdtc_top.sv
// display timing chain, drives and cursor counters
`timescale 1ns/100ps
`default_nettype none
module tdtc_top (
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST_N,
    input  wire logic                       I_CE,
    input  wire logic                       I_PROTECT_MODE,
    input  wire tdtc_pkg::tdtc_cmd_t        I_CMD,
    input  wire logic                       I_ADVANCE,
    input  wire logic [tdtc_pkg::SHIFT_W-1:0] I_PATTERN,
    output logic                            O_DOT_COUNT_MSB_N,
    output tdtc_pkg::tdtc_beam_t            O_BEAM,
    output logic                            O_HDRIVE,
    output logic                            O_VDRIVE,
    output logic                            O_FRAME_TOGGLE,
    output logic                            O_DISPLAY_LINE,
    output logic                            O_CURSOR_MATCH,
    output tdtc_pkg::tdtc_cursor_t          O_WRITE_ADDR,
    output logic                            O_SCROLL,
    output logic                            O_VIDEO
);
    ////////////////////////////////////////////////////////////////////////
    // beam counters
    logic [3:0] dot;
    logic [6:0] col;
    logic [3:0] scan;
    logic [4:0] line;
    logic       frame_toggle;
    logic [6:0] hcount;
    logic       hdrive;

    wire dot_wrap  = (dot == 4'h0);
    wire col_step  = (dot == tdtc_pkg::DOT_TOP);
    wire col_wrap  = col_step && (col == tdtc_pkg::COL_LAST);
    wire scan_wrap = col_wrap && (scan == tdtc_pkg::SCAN_LAST);
    wire line_wrap = scan_wrap && (line == tdtc_pkg::LINE_LAST);
    wire hstart    = col_step && (col == tdtc_pkg::COL_VISIBLE - 7'h01);

    wire [3:0] next_dot  = dot_wrap ? tdtc_pkg::DOT_PRESET : dot + 4'h1; // [RQ2]
    wire [6:0] next_col  = col_wrap ? 7'h00 : col + 7'h01; // [RQ4]
    wire [3:0] next_scan = (scan == tdtc_pkg::SCAN_LAST) ? 4'h0 : scan + 4'h1; // [RQ6]
    wire [4:0] next_line = (line == tdtc_pkg::LINE_LAST) ? 5'h00 : line + 5'h01; // [RQ7]

    always_ff @(posedge I_CLK or negedge I_RST_N) begin // [RQ1]
        if (!I_RST_N) begin
            dot <= tdtc_pkg::DOT_PRESET; // [RQ21]
        end else if (I_CE) begin
            dot <= next_dot;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            col  <= '0; // [RQ21]
            scan <= '0;
            line <= '0;
        end else if (I_CE) begin
            if (col_step) begin
                col <= next_col; // [RQ3]
            end
            if (col_wrap) begin
                scan <= next_scan; // [RQ5]
            end
            if (scan_wrap) begin
                line <= next_line; // [RQ5]
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            frame_toggle <= 1'b0;
        end else if (I_CE && line_wrap) begin
            frame_toggle <= ~frame_toggle; // [RQ7]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // horizontal and vertical drive
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            hdrive <= 1'b0;
            hcount <= '0;
        end else if (I_CE && col_step) begin
            if (hstart) begin
                hdrive <= 1'b1; // [RQ10]
                hcount <= tdtc_pkg::HDRIVE_LEN - 7'h01;
            end else if (hcount != 7'h00) begin
                hcount <= hcount - 7'h01;
            end else begin
                hdrive <= 1'b0; // [RQ10]
            end
        end
    end

    assign O_HDRIVE          = hdrive;
    assign O_VDRIVE          = (line == tdtc_pkg::LINE_VDRIVE); // [RQ11]
    assign O_DISPLAY_LINE    = (line <= tdtc_pkg::ROW_LAST); // [RQ8]
    assign O_FRAME_TOGGLE    = frame_toggle;
    assign O_DOT_COUNT_MSB_N = dot[3]; // [RQ20]
    assign O_BEAM            = '{line: line, scan: scan, col: col, dot: dot}; // [RQ9]

    ////////////////////////////////////////////////////////////////////////
    // cursor counters
    logic [4:0] cur_row;
    logic [6:0] cur_col;
    logic [4:0] roll;
    logic       scroll;

    wire on_last_row = (cur_row == tdtc_pkg::ROW_LAST);
    wire on_last_col = (cur_col == tdtc_pkg::CUR_COL_LAST);
    wire row_down    = (I_CMD == tdtc_pkg::TDTC_CMD_LF) || (I_CMD == tdtc_pkg::TDTC_CMD_DOWN)
                       || (I_ADVANCE && on_last_col);
    wire do_scroll   = row_down && on_last_row && !I_PROTECT_MODE; // [RQ18] [RQ19]
    wire do_wrap     = row_down && on_last_row && I_PROTECT_MODE; // [RQ17]

    logic [4:0] next_row;
    logic [6:0] next_ccol;
    always_comb begin
        next_row  = cur_row;
        next_ccol = cur_col;
        if (I_ADVANCE) begin
            next_ccol = on_last_col ? 7'h00 : cur_col + 7'h01;
        end
        unique case (I_CMD)
            tdtc_pkg::TDTC_CMD_UP: begin
                next_row = (cur_row == 5'h00) ? tdtc_pkg::ROW_LAST : cur_row - 5'h01; // [RQ14]
            end
            tdtc_pkg::TDTC_CMD_RIGHT: begin
                next_ccol = on_last_col ? 7'h00 : cur_col + 7'h01; // [RQ14]
            end
            tdtc_pkg::TDTC_CMD_LEFT: begin
                next_ccol = (cur_col == 7'h00) ? 7'h00 : cur_col - 7'h01; // [RQ14]
            end
            tdtc_pkg::TDTC_CMD_HOME: begin
                next_row  = 5'h00; // [RQ14]
                next_ccol = 7'h00;
            end
            tdtc_pkg::TDTC_CMD_CR: begin
                next_ccol = 7'h00; // [RQ16]
            end
            tdtc_pkg::TDTC_CMD_NONE, tdtc_pkg::TDTC_CMD_DOWN, tdtc_pkg::TDTC_CMD_LF: begin
            end
        endcase
        if (row_down) begin
            if (do_wrap) begin
                next_row = 5'h00; // [RQ17]
            end else if (!do_scroll) begin
                next_row = cur_row + 5'h01; // [RQ15]
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cur_row <= '0; // [RQ21]
            cur_col <= '0;
            roll    <= '0;
            scroll  <= 1'b0;
        end else if (I_CE) begin
            cur_row <= next_row;
            cur_col <= next_ccol;
            scroll  <= do_scroll;
            if (do_scroll) begin
                roll <= (roll == tdtc_pkg::ROW_LAST) ? 5'h00 : roll + 5'h01; // [RQ18]
            end
        end
    end

    assign O_SCROLL       = scroll;
    assign O_CURSOR_MATCH = (cur_row == line) && (cur_col == col); // [RQ12]
    assign O_WRITE_ADDR   = '{row: cur_row, col: cur_col, roll: roll}; // [RQ13]

    ////////////////////////////////////////////////////////////////////////
    // video shift register
    tdtc_shift u_shift (
        .i_clk     (I_CLK),
        .i_rst_n   (I_RST_N),
        .i_ce      (I_CE),
        .i_load_n  (dot[3]),
        .i_pattern (I_PATTERN),
        .o_dot     (O_VIDEO)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_scan_end;
        I_CE && col_wrap;
    endsequence

    sequence s_frame_end;
        I_CE && line_wrap;
    endsequence

    sequence s_scroll_event;
        I_CE && row_down && on_last_row && !I_PROTECT_MODE;
    endsequence

    sequence s_load;
        I_CE && !O_DOT_COUNT_MSB_N;
    endsequence

    property p_dot_wrap;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && dot == 4'h0) |=> (dot == tdtc_pkg::DOT_PRESET);
    endproperty
    a_dot_wrap: assert property (p_dot_wrap) else $error("dot counter did not preset"); // [RQ2]

    property p_dot_step;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && dot != 4'h0) |=> (dot == $past(dot) + 4'h1);
    endproperty
    a_dot_step: assert property (p_dot_step) else $error("dot counter did not step"); // [RQ2]

    property p_col_step;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && dot == tdtc_pkg::DOT_TOP && col != tdtc_pkg::COL_LAST)
        |=> (col == $past(col) + 7'h01);
    endproperty
    a_col_step: assert property (p_col_step) else $error("column did not step"); // [RQ3]

    property p_col_hold;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && dot != tdtc_pkg::DOT_TOP) |=> $stable(col);
    endproperty
    a_col_hold: assert property (p_col_hold) else $error("column moved mid cell"); // [RQ4]

    property p_col_wrap;
        @(posedge I_CLK) disable iff (!I_RST_N)
        s_scan_end |=> (col == 7'h00);
    endproperty
    a_col_wrap: assert property (p_col_wrap) else $error("column did not wrap"); // [RQ4]

    property p_scan_step;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && col_wrap && scan != tdtc_pkg::SCAN_LAST)
        |=> (scan == $past(scan) + 4'h1);
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan did not step"); // [RQ5]

    property p_scan_hold;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && !col_wrap) |=> $stable(scan);
    endproperty
    a_scan_hold: assert property (p_scan_hold) else $error("scan moved mid scan"); // [RQ6]

    property p_line_hold;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && !scan_wrap) |=> $stable(line);
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("line moved mid row"); // [RQ5]

    property p_line_range;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (line <= tdtc_pkg::LINE_LAST) && (scan <= tdtc_pkg::SCAN_LAST);
    endproperty
    a_line_range: assert property (p_line_range) else $error("line or scan too high"); // [RQ7]

    property p_frame_flip;
        @(posedge I_CLK) disable iff (!I_RST_N)
        s_frame_end |=> (O_FRAME_TOGGLE != $past(O_FRAME_TOGGLE));
    endproperty
    a_frame_flip: assert property (p_frame_flip) else $error("frame did not toggle"); // [RQ7]

    property p_frame_hold;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && !line_wrap) |=> $stable(O_FRAME_TOGGLE);
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame toggled early"); // [RQ7]

    property p_vdrive;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && scan_wrap && line == tdtc_pkg::ROW_LAST) |=> O_VDRIVE;
    endproperty
    a_vdrive: assert property (p_vdrive) else $error("vdrive not started"); // [RQ11]

    property p_vdrive_end;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && scan_wrap && line == tdtc_pkg::LINE_VDRIVE) |=> !O_VDRIVE;
    endproperty
    a_vdrive_end: assert property (p_vdrive_end) else $error("vdrive too long"); // [RQ11]

    property p_hstart;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && dot == tdtc_pkg::DOT_TOP && col == tdtc_pkg::COL_VISIBLE - 7'h01)
        |=> O_HDRIVE;
    endproperty
    a_hstart: assert property (p_hstart) else $error("horizontal drive late"); // [RQ10]

    property p_lf;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_CMD == tdtc_pkg::TDTC_CMD_LF && !I_ADVANCE && cur_row < tdtc_pkg::ROW_LAST)
        |=> (cur_row == $past(cur_row) + 5'h01);
    endproperty
    a_lf: assert property (p_lf) else $error("line feed did not step row"); // [RQ15]

    property p_cr;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_CMD == tdtc_pkg::TDTC_CMD_CR) |=> (cur_col == 7'h00);
    endproperty
    a_cr: assert property (p_cr) else $error("return did not clear column"); // [RQ16]

    property p_scroll;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_CMD == tdtc_pkg::TDTC_CMD_LF && cur_row == tdtc_pkg::ROW_LAST && !I_PROTECT_MODE)
        |=> (O_SCROLL && cur_row == tdtc_pkg::ROW_LAST);
    endproperty
    a_scroll: assert property (p_scroll) else $error("no scroll on last row"); // [RQ19]

    property p_wrap;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_CMD == tdtc_pkg::TDTC_CMD_DOWN && cur_row == tdtc_pkg::ROW_LAST && I_PROTECT_MODE)
        |=> (cur_row == 5'h00 && !O_SCROLL);
    endproperty
    a_wrap: assert property (p_wrap) else $error("protected mode did not wrap"); // [RQ17]

    property p_no_scroll;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_PROTECT_MODE) |=> !O_SCROLL;
    endproperty
    a_no_scroll: assert property (p_no_scroll) else $error("scroll in protected mode"); // [RQ17]

    property p_adv_scroll;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_ADVANCE && I_CMD == tdtc_pkg::TDTC_CMD_NONE && !I_PROTECT_MODE
         && on_last_col && on_last_row)
        |=> (O_SCROLL && cur_col == 7'h00 && cur_row == tdtc_pkg::ROW_LAST);
    endproperty
    a_adv_scroll: assert property (p_adv_scroll) else $error("no scroll at last place"); // [RQ19]

    property p_roll_step;
        @(posedge I_CLK) disable iff (!I_RST_N)
        s_scroll_event |=> (roll != $past(roll));
    endproperty
    a_roll_step: assert property (p_roll_step) else $error("scroll offset did not move"); // [RQ18]

    property p_left_stop;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_CMD == tdtc_pkg::TDTC_CMD_LEFT && !I_ADVANCE && cur_col == 7'h00)
        |=> (cur_col == 7'h00);
    endproperty
    a_left_stop: assert property (p_left_stop) else $error("left moved past column 0"); // [RQ14]

    property p_home;
        @(posedge I_CLK) disable iff (!I_RST_N)
        (I_CE && I_CMD == tdtc_pkg::TDTC_CMD_HOME && !I_ADVANCE)
        |=> (cur_row == 5'h00 && cur_col == 7'h00);
    endproperty
    a_home: assert property (p_home) else $error("home did not clear cursor"); // [RQ14]

    property p_video_load;
        @(posedge I_CLK) disable iff (!I_RST_N)
        s_load |=> (O_VIDEO == $past(I_PATTERN[tdtc_pkg::SHIFT_W-1]));
    endproperty
    a_video_load: assert property (p_video_load) else $error("video not loaded"); // [RQ20]
endmodule // tdtc_top
`default_nettype wire

// File: tdtc_crt_model.sv
// crt monitor model measuring horizontal drive period and width
`timescale 1ns/100ps
`default_nettype none
module tdtc_crt_model (
    input  wire logic i_clk,
    input  wire logic i_hdrive,
    output var  int   o_period,
    output var  int   o_width
);
    int   cnt;
    logic last = 1'b0;
    always @(posedge i_clk) begin
        cnt  <= cnt + 1;
        last <= i_hdrive;
        if (i_hdrive === 1'b1 && last === 1'b0) begin
            if (cnt > 0) o_period <= cnt;
            cnt <= 1;
        end
        if (i_hdrive === 1'b0 && last === 1'b1) o_width <= cnt;
    end
endmodule // tdtc_crt_model
`default_nettype wire

// File: test_text_display_timing_cursor.sv
// testbench for the display timing chain and cursor counters
`timescale 1ns/100ps
`default_nettype none
module test_text_display_timing_cursor;
    typedef struct packed {
        logic                p;
        tdtc_pkg::tdtc_cmd_t c;
        logic                a;
        logic [4:0]          r;
        logic [6:0]          col;
        logic [4:0]          roll;
        logic                s;
    } tdtc_row_t;
    localparam tdtc_pkg::tdtc_cmd_t NO = tdtc_pkg::TDTC_CMD_NONE;
    localparam tdtc_pkg::tdtc_cmd_t UP = tdtc_pkg::TDTC_CMD_UP;
    localparam tdtc_pkg::tdtc_cmd_t DN = tdtc_pkg::TDTC_CMD_DOWN;
    localparam tdtc_pkg::tdtc_cmd_t RT = tdtc_pkg::TDTC_CMD_RIGHT;
    localparam tdtc_pkg::tdtc_cmd_t LT = tdtc_pkg::TDTC_CMD_LEFT;
    localparam tdtc_pkg::tdtc_cmd_t HM = tdtc_pkg::TDTC_CMD_HOME;
    localparam tdtc_pkg::tdtc_cmd_t LF = tdtc_pkg::TDTC_CMD_LF;
    localparam tdtc_pkg::tdtc_cmd_t CR = tdtc_pkg::TDTC_CMD_CR;
    localparam logic [6:0]          PAT = 7'h59;
    tdtc_row_t rows [16] = '{
        '{1'b0, RT, 1'b0, 5'h00, 7'h01, 5'h00, 1'b0}, '{1'b0, RT, 1'b0, 5'h00, 7'h02, 5'h00, 1'b0},
        '{1'b0, LT, 1'b0, 5'h00, 7'h01, 5'h00, 1'b0}, '{1'b0, NO, 1'b1, 5'h00, 7'h02, 5'h00, 1'b0},
        '{1'b0, CR, 1'b1, 5'h00, 7'h00, 5'h00, 1'b0}, '{1'b0, LT, 1'b0, 5'h00, 7'h00, 5'h00, 1'b0},
        '{1'b0, DN, 1'b0, 5'h01, 7'h00, 5'h00, 1'b0}, '{1'b0, LF, 1'b0, 5'h02, 7'h00, 5'h00, 1'b0},
        '{1'b0, RT, 1'b0, 5'h02, 7'h01, 5'h00, 1'b0}, '{1'b0, HM, 1'b0, 5'h00, 7'h00, 5'h00, 1'b0},
        '{1'b0, UP, 1'b0, 5'h17, 7'h00, 5'h00, 1'b0}, '{1'b0, LF, 1'b0, 5'h17, 7'h00, 5'h01, 1'b1},
        '{1'b0, DN, 1'b0, 5'h17, 7'h00, 5'h02, 1'b1}, '{1'b1, LF, 1'b0, 5'h00, 7'h00, 5'h02, 1'b0},
        '{1'b1, UP, 1'b0, 5'h17, 7'h00, 5'h02, 1'b0}, '{1'b1, DN, 1'b0, 5'h00, 7'h00, 5'h02, 1'b0}};
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   ce = 1'b1;
    logic                   prot = 1'b0;
    tdtc_pkg::tdtc_cmd_t    cmd = NO;
    logic                   adv = 1'b0;
    logic                   msb_n, hd, vd, dl, cm, scr, vid, ft;
    tdtc_pkg::tdtc_beam_t   beam, held;
    tdtc_pkg::tdtc_cursor_t wa;
    int                     errors = 0;
    int                     compares = 0;
    int                     cyc = 0;
    int                     period, width;
    logic [3:0]             dots [8] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h0, 4'hA};
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;
    tdtc_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PROTECT_MODE(prot), .I_CMD(cmd),
        .I_ADVANCE(adv), .I_PATTERN(PAT), .O_DOT_COUNT_MSB_N(msb_n), .O_BEAM(beam),
        .O_HDRIVE(hd), .O_VDRIVE(vd), .O_FRAME_TOGGLE(ft), .O_DISPLAY_LINE(dl),
        .O_CURSOR_MATCH(cm), .O_WRITE_ADDR(wa), .O_SCROLL(scr), .O_VIDEO(vid));
    tdtc_crt_model crt (.i_clk(clk), .i_hdrive(hd), .o_period(period), .o_width(width));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input logic p, input tdtc_pkg::tdtc_cmd_t c, input logic a);
        @(posedge clk);
        prot <= p;
        cmd <= c;
        adv <= a;
        @(posedge clk);
        cmd <= NO;
        adv <= 1'b0;
        @(negedge clk);
    endtask
    task automatic at_cycle(input int k);
        while (cyc < k) @(negedge clk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 30000);
        errors++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        check({beam.dot, beam.col, beam.scan, beam.line}, {4'hA, 16'h0000});
        check({wa, hd, vd, cm, vid}, {17'h00000, 4'b0010});
        @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            at_cycle(k);
            check(beam.dot, dots[k]);
            check(msb_n, dots[k][3]);
        end
        check(beam.col, 7'h01);
        for (int i = 0; i < 16; i++) begin
            step(rows[i].p, rows[i].c, rows[i].a);
            check(wa.row, rows[i].r);
            check(wa.col, rows[i].col);
            check(wa.roll, rows[i].roll);
            check(scr, rows[i].s);
        end
        at_cycle(96 * 7);
        check({beam.scan, beam.col, beam.dot}, {4'h1, 7'h00, 4'hA});
        at_cycle(1000);
        while (cyc < 1800 && !(beam.col === 7'h00 && beam.dot === 4'hA)) @(negedge clk);
        if (cyc >= 1800) errors++;
        check(cm, 1'b1);
        repeat (7) @(negedge clk);
        check(cm, 1'b0);
        while (cyc < 2600 && msb_n !== 1'b0) @(negedge clk);
        if (cyc >= 2600) errors++;
        for (int i = 6; i >= 0; i--) begin
            @(negedge clk);
            check(vid, PAT[i]);
        end
        check(period, 32'd672);
        check(width, 32'd280);
        step(1'b0, UP, 1'b0);
        for (int i = 0; i < 79; i++) step(1'b0, NO, 1'b1);
        check(wa.col, 7'h4F);
        step(1'b0, NO, 1'b1);
        check({wa, scr}, {5'h17, 7'h00, 5'h03, 1'b1});
        at_cycle(96 * 7 * 10);
        check({beam.line, beam.scan, beam.col, dl, vd}, {5'h01, 4'h0, 7'h00, 2'b10});
        check(ft, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        held = beam;
        repeat (5) @(negedge clk);
        check(beam, held);
        @(posedge clk);
        ce <= 1'b1;
        end_of_test;
    end
endmodule // test_text_display_timing_cursor
`default_nettype wire
